/* File: pkg/pin_out_select_pkg.sv */
// Package: register map, field layout and types for the pin output select
package pin_out_select_pkg;

  localparam int unsigned NUM_REGS       = 7;
  localparam int unsigned FIRST_PIN      = 2;
  localparam int unsigned NUM_PINS       = 14;
  localparam int unsigned SEL_W          = 6;
  localparam int unsigned NUM_FUNCS      = 64;

  // Byte offsets of the seven selection registers
  localparam logic [11:0] OFS_PINS_2_3   = 12'h000;
  localparam logic [11:0] OFS_PINS_4_5   = 12'h004;
  localparam logic [11:0] OFS_PINS_6_7   = 12'h008;
  localparam logic [11:0] OFS_PINS_8_9   = 12'h00C;
  localparam logic [11:0] OFS_PINS_10_11 = 12'h010;
  localparam logic [11:0] OFS_PINS_12_13 = 12'h014;
  localparam logic [11:0] OFS_PINS_14_15 = 12'h018;
  localparam logic [11:0] OFS_LAST       = OFS_PINS_14_15;

  // Field positions inside a selection register
  localparam int unsigned EVEN_LSB       = 0;
  localparam int unsigned ODD_LSB        = 8;

  localparam logic [5:0]  SEL_RESET      = 6'h00;
  localparam logic [5:0]  SEL_NONE       = 6'h00;

  // Register index whose odd field is absent on the reduced variant
  localparam int unsigned IDX_PIN5       = 1;
  localparam int unsigned IDX_PIN15      = 6;

  typedef struct packed {
    logic [5:0] odd_sel;
    logic [5:0] even_sel;
  } sel_pair_s;

endpackage : pin_out_select_pkg

/* File: verilog/remappable_pin_output_select.sv */
// Remappable pin output select: APB registers and per-pin function mux
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module remappable_pin_output_select #(
  parameter bit REDUCED_PINS = 1'b0           // Reduced pin-count variant
) (
  input  wire logic        clk_i,             // System clock
  input  wire logic        rstn_i,            // Async reset, active low
  input  wire logic        psel_i,            // APB select
  input  wire logic        penable_i,         // APB enable
  input  wire logic        pwrite_i,          // APB write
  input  wire logic [11:0] paddr_i,           // APB byte address
  input  wire logic [31:0] pwdata_i,          // APB write data
  input  wire logic [3:0]  pstrb_i,           // APB byte strobes
  output logic             pready_o,          // APB ready
  output logic [31:0]      prdata_o,          // APB read data
  output logic             pslverr_o,         // APB error
  input  wire logic [63:0] func_i,            // Peripheral output functions
  output logic [13:0]      pin_o,             // Pin value, pins 2..15
  output logic [13:0]      pin_periph_o       // Pin taken by a peripheral
);

  localparam int unsigned NR = pin_out_select_pkg::NUM_REGS;
  localparam int unsigned NP = pin_out_select_pkg::NUM_PINS;

  pin_out_select_pkg::sel_pair_s sel_ff [NR];

  logic [2:0]  reg_idx;
  logic        addr_hit;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] nxt_rdata;

  // Word index and decode of the register window
  assign reg_idx  = paddr_i[4:2];
  assign addr_hit = (paddr_i[1:0] == 2'b00) &&
                    (paddr_i <= pin_out_select_pkg::OFS_LAST);
  assign wr_en    = psel_i && penable_i && pwrite_i && addr_hit && !pready_o;
  assign rd_en    = psel_i && penable_i && !pwrite_i && addr_hit && !pready_o;

  // Selector storage, one register per pin pair
  genvar k;
  generate
    for (k = 0; k < NR; k++) begin : g_reg
      localparam bit ODD_ABSENT = REDUCED_PINS &&
        ((k == pin_out_select_pkg::IDX_PIN5) ||
         (k == pin_out_select_pkg::IDX_PIN15));
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sel_ff[k] <= '{odd_sel: pin_out_select_pkg::SEL_RESET,
                         even_sel: pin_out_select_pkg::SEL_RESET};
        end else if (wr_en && (reg_idx == 3'(k))) begin
          if (pstrb_i[0]) begin
            sel_ff[k].even_sel <= pwdata_i[5:0];
          end
          if (pstrb_i[1] && !ODD_ABSENT) begin
            sel_ff[k].odd_sel <= pwdata_i[13:8];
          end
        end
      end
    end
  endgenerate

  // Read mux; gap bits return zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_en) begin
      nxt_rdata[13:8] = sel_ff[reg_idx].odd_sel;
      nxt_rdata[5:0]  = sel_ff[reg_idx].even_sel;
    end
  end

  // APB answer in the second access cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      prdata_o  <= nxt_rdata;
      pslverr_o <= psel_i && penable_i && !pready_o && !addr_hit;
    end
  end

  // Pin multiplexer, one per remappable pin
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_pin
      logic [5:0] sel;
      assign sel = ((p % 2) != 0) ? sel_ff[p/2].odd_sel
                                  : sel_ff[p/2].even_sel;
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pin_o[p]        <= 1'b0;
          pin_periph_o[p] <= 1'b0;
        end else begin
          pin_periph_o[p] <= (sel != pin_out_select_pkg::SEL_NONE);
          pin_o[p]        <= (sel != pin_out_select_pkg::SEL_NONE) &&
                             func_i[sel];
        end
      end
    end
  endgenerate

  // Checks
  sequence apb_wr_s;
    psel_i && penable_i && pwrite_i && !pready_o && addr_hit && pstrb_i[0];
  endsequence

  write_lands_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    apb_wr_s |=> sel_ff[$past(reg_idx)].even_sel == $past(pwdata_i[5:0]))
    else $error("even selector not stored");

  gap_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    prdata_o[15:14] == 2'b00 && prdata_o[7:6] == 2'b00 &&
    prdata_o[31:16] == 16'h0000)
    else $error("unimplemented bits read nonzero");

  read_back_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_en |=> prdata_o[5:0] == $past(sel_ff[reg_idx].even_sel) && pready_o)
    else $error("read data mismatch");

  pin2_func_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sel_ff[0].even_sel != 6'h00 |=>
      pin_o[0] == $past(func_i[sel_ff[0].even_sel]))
    else $error("pin 2 not driven from selected function");

  pin3_map_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[1] == ($past(sel_ff[0].odd_sel) != 6'h00))
    else $error("pin 3 owner flag wrong");

  sel_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sel_ff[3].even_sel == 6'h00 |=> !pin_o[6] && !pin_periph_o[6])
    else $error("zero selector drives pin");

  pin5_absent_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    REDUCED_PINS |-> sel_ff[1].odd_sel == 6'h00)
    else $error("pin 5 selector exists on reduced variant");

  pin15_absent_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    REDUCED_PINS |-> sel_ff[6].odd_sel == 6'h00 && !pin_periph_o[13])
    else $error("pin 15 selector exists on reduced variant");

  ready_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pready_o |=> !pready_o)
    else $error("pready held more than one cycle");

  // Odd selector stores, absent fields stay zero on the reduced variant
  pin3_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && reg_idx == 3'd0 && pstrb_i[1] |=>
      sel_ff[0].odd_sel == $past(pwdata_i[13:8]))
    else $error("pin 3 selector not stored");

  pin5_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && reg_idx == 3'd1 && pstrb_i[1] |=>
      sel_ff[1].odd_sel == (REDUCED_PINS ? 6'h00 : $past(pwdata_i[13:8])))
    else $error("pin 5 selector store wrong");

  pin7_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && reg_idx == 3'd2 && pstrb_i[1] |=>
      sel_ff[2].odd_sel == $past(pwdata_i[13:8]))
    else $error("pin 7 selector not stored");

  pin9_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && reg_idx == 3'd3 && pstrb_i[1] |=>
      sel_ff[3].odd_sel == $past(pwdata_i[13:8]))
    else $error("pin 9 selector not stored");

  pin11_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && reg_idx == 3'd4 && pstrb_i[1] |=>
      sel_ff[4].odd_sel == $past(pwdata_i[13:8]))
    else $error("pin 11 selector not stored");

  pin13_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && reg_idx == 3'd5 && pstrb_i[1] |=>
      sel_ff[5].odd_sel == $past(pwdata_i[13:8]))
    else $error("pin 13 selector not stored");

  pin15_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && reg_idx == 3'd6 && pstrb_i[1] |=>
      sel_ff[6].odd_sel == (REDUCED_PINS ? 6'h00 : $past(pwdata_i[13:8])))
    else $error("pin 15 selector store wrong");

  // Per-pin route and owner flag, one clock behind the selector
  pin2_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[0] == ($past(sel_ff[0].even_sel) != 6'h00) &&
        pin_o[0] == ($past(sel_ff[0].even_sel) != 6'h00 &&
                     $past(func_i[sel_ff[0].even_sel])))
    else $error("pin 2 route wrong");

  pin3_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[1] == ($past(sel_ff[0].odd_sel) != 6'h00) &&
        pin_o[1] == ($past(sel_ff[0].odd_sel) != 6'h00 &&
                     $past(func_i[sel_ff[0].odd_sel])))
    else $error("pin 3 route wrong");

  pin4_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[2] == ($past(sel_ff[1].even_sel) != 6'h00) &&
        pin_o[2] == ($past(sel_ff[1].even_sel) != 6'h00 &&
                     $past(func_i[sel_ff[1].even_sel])))
    else $error("pin 4 route wrong");

  pin5_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[3] == ($past(sel_ff[1].odd_sel) != 6'h00) &&
        pin_o[3] == ($past(sel_ff[1].odd_sel) != 6'h00 &&
                     $past(func_i[sel_ff[1].odd_sel])))
    else $error("pin 5 route wrong");

  pin6_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[4] == ($past(sel_ff[2].even_sel) != 6'h00) &&
        pin_o[4] == ($past(sel_ff[2].even_sel) != 6'h00 &&
                     $past(func_i[sel_ff[2].even_sel])))
    else $error("pin 6 route wrong");

  pin7_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[5] == ($past(sel_ff[2].odd_sel) != 6'h00) &&
        pin_o[5] == ($past(sel_ff[2].odd_sel) != 6'h00 &&
                     $past(func_i[sel_ff[2].odd_sel])))
    else $error("pin 7 route wrong");

  pin8_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[6] == ($past(sel_ff[3].even_sel) != 6'h00) &&
        pin_o[6] == ($past(sel_ff[3].even_sel) != 6'h00 &&
                     $past(func_i[sel_ff[3].even_sel])))
    else $error("pin 8 route wrong");

  pin9_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[7] == ($past(sel_ff[3].odd_sel) != 6'h00) &&
        pin_o[7] == ($past(sel_ff[3].odd_sel) != 6'h00 &&
                     $past(func_i[sel_ff[3].odd_sel])))
    else $error("pin 9 route wrong");

  pin10_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[8] == ($past(sel_ff[4].even_sel) != 6'h00) &&
        pin_o[8] == ($past(sel_ff[4].even_sel) != 6'h00 &&
                     $past(func_i[sel_ff[4].even_sel])))
    else $error("pin 10 route wrong");

  pin11_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[9] == ($past(sel_ff[4].odd_sel) != 6'h00) &&
        pin_o[9] == ($past(sel_ff[4].odd_sel) != 6'h00 &&
                     $past(func_i[sel_ff[4].odd_sel])))
    else $error("pin 11 route wrong");

  pin12_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[10] == ($past(sel_ff[5].even_sel) != 6'h00) &&
        pin_o[10] == ($past(sel_ff[5].even_sel) != 6'h00 &&
                      $past(func_i[sel_ff[5].even_sel])))
    else $error("pin 12 route wrong");

  pin13_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[11] == ($past(sel_ff[5].odd_sel) != 6'h00) &&
        pin_o[11] == ($past(sel_ff[5].odd_sel) != 6'h00 &&
                      $past(func_i[sel_ff[5].odd_sel])))
    else $error("pin 13 route wrong");

  pin14_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[12] == ($past(sel_ff[6].even_sel) != 6'h00) &&
        pin_o[12] == ($past(sel_ff[6].even_sel) != 6'h00 &&
                      $past(func_i[sel_ff[6].even_sel])))
    else $error("pin 14 route wrong");

  pin15_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 pin_periph_o[13] == ($past(sel_ff[6].odd_sel) != 6'h00) &&
        pin_o[13] == ($past(sel_ff[6].odd_sel) != 6'h00 &&
                      $past(func_i[sel_ff[6].odd_sel])))
    else $error("pin 15 route wrong");

endmodule // remappable_pin_output_select

/* File: tb/func_source.sv */
// Peripheral output function source feeding the pin mux
`timescale 1ns/1ps
module func_source (
  input  wire logic        clk_i,  // Clock
  input  wire logic        rstn_i, // Reset, active low
  input  wire logic [63:0] mix_i,  // Random mix-in
  output logic      [63:0] func_o  // Function outputs
);
  // Fresh pattern each cycle so a stale route shows up
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) func_o <= '0;
    else func_o <= {func_o[62:0], ~func_o[63]} ^ mix_i;
  end
endmodule // func_source

/* File: tb/tb_top.sv */
// Testbench: register access and pin routing of the output select
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d, m;
  logic        pready, pslverr;
  logic [63:0] func, mix = '0, prev_func = '0;
  logic [13:0] pin, pin_p, ep, epp;
  logic [5:0]  sel_m [14];
  logic [33:0] q [$];
  logic [33:0] e;
  int          err_total = 0, num_checks = 0, cyc = 0;
  integer      seed = 78765;
  remappable_pin_output_select #(.REDUCED_PINS(1'b1))
    remappable_pin_output_select_inst (.clk_i(clk), .rstn_i(rstn),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .func_i(func), .pin_o(pin),
    .pin_periph_o(pin_p));
  func_source func_source_inst (.clk_i(clk), .rstn_i(rstn), .mix_i(mix),
    .func_o(func));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Setup, access, hold until ready, then release
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dv, input logic [33:0] ex);
    @(posedge clk);
    q.push_back(ex);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  always #50 clk = ~clk;
  always @(posedge clk) begin
    mix <= {$random(seed), $random(seed)};
    prev_func <= func;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
    if (pready === 1'b1) begin
      e = q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) chk(prdata, e[31:0]);
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b1, 12'h01c, '1, {2'b01, 32'h0});
    apb(1'b0, 12'h002, '0, {2'b11, 32'h0});
    for (int k = 0; k < 7; k++) apb(1'b0, 12'(4*k), '0, 34'h2_0000_0000);
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 7; k++) begin
        d = (r == 2) ? '0 : $random(seed);
        m = (k == 1 || k == 6) ? 32'h0000_003f : 32'h0000_3f3f;
        sel_m[2*k] = d[5:0];
        sel_m[2*k+1] = d[13:8] & m[13:8];
        apb(1'b1, 12'(4*k), d, '0);
        apb(1'b0, 12'(4*k), '0, {2'b10, d & m});
      end
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int i = 0; i < 14; i++) begin
        epp[i] = (sel_m[i] != 6'h00);
        ep[i] = epp[i] & prev_func[sel_m[i]];
      end
      chk({18'h0, pin}, {18'h0, ep});
      chk({18'h0, pin_p}, {18'h0, epp});
    end
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule // tb_top
